// ---- design/rio_consts.svh ----
// Constants of the remote I/O control block: offsets, fields, reset values, timing counts
`ifndef RIO_CONSTS_SVH
`define RIO_CONSTS_SVH

// Register byte offsets
`define RIO_CTRL_OFS 8'h00
`define RIO_STAT_OFS 8'h04
`define RIO_SWPT_OFS 8'h08
`define RIO_STBY_OFS 8'h0C
`define RIO_ADDR_OFS 8'h10
`define RIO_ERR_OFS 8'h14

// Control and input bit positions (same order for pins and software bits)
`define RIO_B_VENT 0
`define RIO_B_MOTOR 1
`define RIO_B_STATION 2
`define RIO_B_STANDBY 3
`define RIO_B_HEATER 4
`define RIO_B_SEAL 5
`define RIO_B_ACK 6
`define RIO_B_PRIO 7

// Reset values
`define RIO_SWPT_RST 7'h50
`define RIO_STBY_RST 10'h29B
`define RIO_ADDR_RST 10'h001
`define RIO_CTRL_RST 6'h00

// Fixed values
`define RIO_GROUP_ADDR 10'h3C2
`define RIO_MIN_SET_PCT 7'h14
`define RIO_NOMINAL_PCT 7'h64
`define RIO_NOMINAL_PML 10'h3E8

// Timing: figures as printed, cycles derived from the 25 MHz clock
`define RIO_CLK_HZ 25000000
`define RIO_SELFTEST_S 8
`define RIO_SELFTEST_CYC (`RIO_SELFTEST_S * `RIO_CLK_HZ)
`define RIO_ACK_MS 500
`define RIO_ACK_CYC (`RIO_ACK_MS * (`RIO_CLK_HZ / 1000))
`define RIO_DEB_US 100
`define RIO_DEB_CYC (`RIO_DEB_US * (`RIO_CLK_HZ / 1000000))
`define RIO_BAUD 9600
`define RIO_BAUD_CYC (`RIO_CLK_HZ / `RIO_BAUD)

`endif

// ---- design/rio_pkg.sv ----
// Types of the remote I/O control block
package rio_pkg;
  // Station sequencing states
  typedef enum logic [1:0] {
    RIO_ST_OFF = 2'b00,
    RIO_ST_TEST = 2'b01,
    RIO_ST_ON = 2'b10,
    RIO_ST_FAIL = 2'b11
  } rio_station_type;
endpackage : rio_pkg

// ---- design/rio_remote_ctrl.sv ----
// Remote connector control logic of a turbopump drive unit, with an APB register slave
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "rio_consts.svh"

module rio_remote_ctrl
  import rio_pkg::*;
#(
  parameter logic [31:0] SELFTEST_CYC = `RIO_SELFTEST_CYC,
  parameter logic [31:0] ACK_CYC = `RIO_ACK_CYC
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Connector pins, asynchronous
  input wire logic vent_enable_in_i,
  input wire logic motor_on_in_i,
  input wire logic station_on_in_i,
  input wire logic reduced_speed_in_i,
  input wire logic heater_in_i,
  input wire logic seal_gas_in_i,
  input wire logic fault_ack_in_i,
  input wire logic local_priority_in_i,
  // Setpoint from on-chip converter, tenths of a volt (0..100)
  input wire logic [6:0] speed_setpoint_pos_i,
  // Drive core status, same clock
  input wire logic [6:0] rotor_speed_pct_i,
  input wire logic [7:0] error_cause_i,
  input wire logic warning_i,
  input wire logic selftest_pass_i,
  input wire logic supply_ok_i,
  // Serial frame address from the receiver
  input wire logic [9:0] frame_addr_i,
  input wire logic frame_addr_valid_i,
  // Outputs
  output logic speed_reached_out_o,
  output logic no_fault_out_o,
  output logic priority_out_o,
  output logic [6:0] speed_level_out_o,
  output logic relay_speed_o,
  output logic relay_fault_free_o,
  output logic relay_warning_o,
  output logic vent_permit_o,
  output logic motor_run_o,
  output logic station_run_o,
  output logic heater_on_o,
  output logic seal_gas_open_o,
  output logic [9:0] target_speed_pml_o,
  output logic addr_match_o,
  output logic baud_tick_o
);

  // ************************************************************
  // Input conditioning
  // ************************************************************
  logic [7:0] pin_raw; // Raw pin vector in control-bit order
  logic [7:0] sync1_reg; // First synchroniser stage, read only by stage two
  logic [7:0] sync2_reg; // Second synchroniser stage
  logic [7:0] deb_reg; // Debounced pin levels

  assign pin_raw = {local_priority_in_i, fault_ack_in_i, seal_gas_in_i, heater_in_i,
                    reduced_speed_in_i, station_on_in_i, motor_on_in_i, vent_enable_in_i};

  // Two-flop synchroniser; open lines read low so they count as inactive
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Debounce: a level must stay stable for the whole window before it is taken
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_deb
      logic [11:0] cnt_reg; // Stability counter of this line
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          cnt_reg <= 12'h000;
          deb_reg[gi] <= 1'b0;
        end else if (sync2_reg[gi] == deb_reg[gi]) begin
          cnt_reg <= 12'h000; // Agrees with output, restart window
        end else if (cnt_reg == 12'(`RIO_DEB_CYC - 1)) begin
          cnt_reg <= 12'h000;
          deb_reg[gi] <= sync2_reg[gi];
        end else begin
          cnt_reg <= cnt_reg + 12'h001;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Registers
  // ************************************************************
  logic [5:0] ctrl_reg; // Software control bits, used without remote priority
  logic [6:0] swpt_reg; // Speed switch point in percent
  logic [9:0] stby_reg; // Standby speed in per mille
  logic [9:0] addr_reg; // Own serial bus address
  logic [7:0] err_pend_reg; // Pending error flags
  logic sw_ack_reg; // One-cycle pulse from a software acknowledge
  logic wr_en; // Write takes effect this edge
  logic rd_en; // Read data taken this edge

  assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;

  // Software-written configuration
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= `RIO_CTRL_RST;
      swpt_reg <= `RIO_SWPT_RST;
      stby_reg <= `RIO_STBY_RST;
      addr_reg <= `RIO_ADDR_RST;
      sw_ack_reg <= 1'b0;
    end else begin
      sw_ack_reg <= 1'b0;
      if (wr_en) begin
        unique case (paddr_i)
          `RIO_CTRL_OFS: begin
            ctrl_reg <= pwdata_i[5:0];
            sw_ack_reg <= pwdata_i[`RIO_B_ACK]; // Acknowledge bit is a write pulse
          end
          `RIO_SWPT_OFS: swpt_reg <= pwdata_i[6:0];
          `RIO_STBY_OFS: stby_reg <= pwdata_i[9:0];
          `RIO_ADDR_OFS: addr_reg <= pwdata_i[9:0];
          default: begin
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Control source selection
  // ************************************************************
  logic prio; // Remote connector has priority
  logic [5:0] eff; // Effective control bits
  assign prio = deb_reg[`RIO_B_PRIO];
  // Pins win over software only while priority is held; otherwise pins are ignored
  assign eff = prio ? deb_reg[5:0] : ctrl_reg;

  // ************************************************************
  // Error acknowledge and error flags
  // ************************************************************
  logic [31:0] ack_cnt_reg; // How long the acknowledge pin has been high
  logic ack_pulse; // Acknowledge held long enough, one cycle
  logic station_q_reg; // Previous effective station level
  logic station_rise; // Station just switched on
  logic err_clear; // Clear request for vanished errors

  // Count the acknowledge level; the pin is only honoured under remote priority
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_cnt_reg <= 32'h0000_0000;
    end else if (!(prio & deb_reg[`RIO_B_ACK])) begin
      ack_cnt_reg <= 32'h0000_0000;
    end else if (ack_cnt_reg != ACK_CYC) begin
      ack_cnt_reg <= ack_cnt_reg + 32'h0000_0001; // Saturates: one clear per pulse
    end
  end
  assign ack_pulse = prio & deb_reg[`RIO_B_ACK] & (ack_cnt_reg == ACK_CYC - 32'h0000_0001);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      station_q_reg <= 1'b0;
    end else begin
      station_q_reg <= eff[`RIO_B_STATION];
    end
  end
  assign station_rise = eff[`RIO_B_STATION] & ~station_q_reg;
  assign err_clear = ack_pulse | sw_ack_reg | station_rise;

  // A live cause sets its flag in the same cycle a clear arrives, so set wins
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      err_pend_reg <= 8'h00;
    end else begin
      err_pend_reg <= (err_clear ? 8'h00 : err_pend_reg) | error_cause_i;
    end
  end

  // ************************************************************
  // Station sequencing and self-test
  // ************************************************************
  rio_station_type st_reg; // Station state
  logic [31:0] test_cnt_reg; // Self-test time

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= RIO_ST_OFF;
      test_cnt_reg <= 32'h0000_0000;
    end else if (!eff[`RIO_B_STATION]) begin
      st_reg <= RIO_ST_OFF;
      test_cnt_reg <= 32'h0000_0000;
    end else begin
      unique case (st_reg)
        RIO_ST_OFF: begin
          st_reg <= RIO_ST_TEST;
          test_cnt_reg <= 32'h0000_0000;
        end
        RIO_ST_TEST: begin
          if (test_cnt_reg == SELFTEST_CYC - 32'h0000_0001) begin
            st_reg <= selftest_pass_i ? RIO_ST_ON : RIO_ST_FAIL;
          end else begin
            test_cnt_reg <= test_cnt_reg + 32'h0000_0001;
          end
        end
        RIO_ST_ON: st_reg <= RIO_ST_ON; // Stays on; motor follows its input
        RIO_ST_FAIL: st_reg <= RIO_ST_FAIL; // Needs station off then on
      endcase
    end
  end

  // ************************************************************
  // Speed target and outputs
  // ************************************************************
  logic [9:0] target_next; // Speed target in per mille
  logic any_err; // Collective error

  // Standby overrides the analog setpoint; below 2 V the pump runs at nominal
  always_comb begin
    if (eff[`RIO_B_STANDBY]) begin
      target_next = stby_reg;
    end else if (speed_setpoint_pos_i < `RIO_MIN_SET_PCT || speed_setpoint_pos_i > `RIO_NOMINAL_PCT) begin
      target_next = `RIO_NOMINAL_PML;
    end else begin
      // Widen before the product so that codes above 12 do not wrap in seven bits
      target_next = 10'(speed_setpoint_pos_i) * 10'h00A;
    end
  end
  assign any_err = (err_pend_reg != 8'h00);

  // All pin-facing outputs are registered
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      speed_reached_out_o <= 1'b0;
      no_fault_out_o <= 1'b0;
      priority_out_o <= 1'b0;
      speed_level_out_o <= 7'h00;
      relay_speed_o <= 1'b0;
      relay_fault_free_o <= 1'b0;
      relay_warning_o <= 1'b0;
      vent_permit_o <= 1'b0;
      motor_run_o <= 1'b0;
      station_run_o <= 1'b0;
      heater_on_o <= 1'b0;
      seal_gas_open_o <= 1'b0;
      target_speed_pml_o <= `RIO_NOMINAL_PML;
    end else begin
      speed_reached_out_o <= (rotor_speed_pct_i >= swpt_reg);
      relay_speed_o <= (rotor_speed_pct_i >= swpt_reg);
      no_fault_out_o <= supply_ok_i & ~any_err;
      relay_fault_free_o <= supply_ok_i & ~any_err;
      relay_warning_o <= warning_i;
      priority_out_o <= prio;
      speed_level_out_o <= rotor_speed_pct_i;
      vent_permit_o <= eff[`RIO_B_VENT];
      // Motor off does not leave the on state, so no venting is triggered
      motor_run_o <= (st_reg == RIO_ST_ON) & eff[`RIO_B_MOTOR];
      station_run_o <= eff[`RIO_B_STATION];
      heater_on_o <= eff[`RIO_B_HEATER];
      seal_gas_open_o <= eff[`RIO_B_SEAL];
      target_speed_pml_o <= target_next;
    end
  end

  // ************************************************************
  // Serial port timing and addressing
  // ************************************************************
  logic [11:0] baud_cnt_reg; // Bit-time divider

  // Bit tick for the 9600 baud 8N1 port; both ends must agree on this rate
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      baud_cnt_reg <= 12'h000;
      baud_tick_o <= 1'b0;
    end else if (baud_cnt_reg == 12'(`RIO_BAUD_CYC - 1)) begin
      baud_cnt_reg <= 12'h000;
      baud_tick_o <= 1'b1;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 12'h001;
      baud_tick_o <= 1'b0;
    end
  end

  // Frames to the own address or the group address are accepted
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_match_o <= 1'b0;
    end else begin
      addr_match_o <= frame_addr_valid_i & ((frame_addr_i == addr_reg) ||
                      (frame_addr_i == `RIO_GROUP_ADDR));
    end
  end

  // ************************************************************
  // APB answer: one wait-free access phase, read data latched in setup
  // ************************************************************
  logic [31:0] rdata_next; // Read mux
  logic unmapped; // Address decodes to no register

  always_comb begin
    rdata_next = 32'h0000_0000;
    unmapped = 1'b0;
    unique case (paddr_i)
      `RIO_CTRL_OFS: rdata_next = {26'h0, ctrl_reg};
      `RIO_STAT_OFS: rdata_next = {18'h0, st_reg, any_err, warning_i, motor_run_o, prio, deb_reg};
      `RIO_SWPT_OFS: rdata_next = {25'h0, swpt_reg};
      `RIO_STBY_OFS: rdata_next = {22'h0, stby_reg};
      `RIO_ADDR_OFS: rdata_next = {22'h0, addr_reg};
      `RIO_ERR_OFS: rdata_next = {24'h0, err_pend_reg};
      default: unmapped = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= psel_i & ~penable_i; // High in the first access cycle
      pslverr_o <= psel_i & ~penable_i & unmapped;
      if (rd_en) begin
        prdata_o <= rdata_next;
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sync_order_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    sync2_reg == $past(sync1_reg)) else $error("Synchroniser stage skipped");
  vent_lock_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !eff[`RIO_B_VENT] |=> !vent_permit_o) else $error("Venting permitted while locked");
  motor_test_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    station_rise |=> !motor_run_o [*2]) else $error("Motor ran before self-test");
  motor_toggle_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (st_reg == RIO_ST_ON && eff[`RIO_B_STATION] && $fell(eff[`RIO_B_MOTOR])) |=> st_reg == RIO_ST_ON)
    else $error("Motor off left station state");
  station_off_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !eff[`RIO_B_STATION] |=> st_reg == RIO_ST_OFF ##0 !station_run_o) else $error("Station not off");
  standby_speed_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    eff[`RIO_B_STANDBY] |=> target_speed_pml_o == $past(stby_reg)) else $error("Standby speed wrong");
  heat_seal_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    1'b1 |=> heater_on_o == $past(eff[`RIO_B_HEATER]) && seal_gas_open_o == $past(eff[`RIO_B_SEAL]))
    else $error("Heater or valve mismatch");
  ack_clear_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ack_pulse |=> err_pend_reg == $past(error_cause_i)) else $error("Acknowledge did not clear");
  prio_ignore_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !prio |-> eff == ctrl_reg) else $error("Pins used without priority");
  low_set_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (!eff[`RIO_B_STANDBY] && speed_setpoint_pos_i < `RIO_MIN_SET_PCT) |=> target_speed_pml_o == `RIO_NOMINAL_PML)
    else $error("Low setpoint not nominal");
  switch_pt_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (rotor_speed_pct_i >= swpt_reg) |=> speed_reached_out_o && relay_speed_o)
    else $error("Switch point output missing");
  fault_out_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (error_cause_i != 8'h00) |=> ##1 !no_fault_out_o && !relay_fault_free_o)
    else $error("Error not reported");
  warn_relay_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    warning_i |=> relay_warning_o) else $error("Warning relay idle");
  speed_level_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    1'b1 |=> speed_level_out_o == $past(rotor_speed_pct_i)) else $error("Speed output wrong");
  group_addr_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (frame_addr_valid_i && frame_addr_i == `RIO_GROUP_ADDR) |=> addr_match_o)
    else $error("Group address missed");
  baud_space_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    baud_tick_o |=> !baud_tick_o [*8]) else $error("Baud ticks too close");

endmodule : rio_remote_ctrl

// ---- bench/rio_plc_model.sv ----
// Behavioural controller model that drives the remote connector inputs
`timescale 1ns/1ps
module rio_plc_model #(
  parameter int ACK_HOLD = 2600
) (
  input wire logic clk_i,
  input wire logic [7:0] level_i,
  input wire logic ack_req_i,
  output logic [7:0] pins_o
);
  int hold_cnt; // Cycles left of the acknowledge pulse

  initial begin
    pins_o = 8'h00;
    hold_cnt = 0;
  end

  // Lines are driven high to assert and low to release, never left floating
  // The pulse outlasts debounce plus the acknowledge time, since a short one goes unseen
  always @(posedge clk_i) begin
    if (ack_req_i) begin
      hold_cnt <= ACK_HOLD;
    end else if (hold_cnt != 0) begin
      hold_cnt <= hold_cnt - 1;
    end
    pins_o <= (level_i & 8'hBF) | {1'b0, hold_cnt != 0, 6'h00};
  end
endmodule : rio_plc_model

// ---- bench/remote_io_control_tb.sv ----
// Self-checking testbench of the remote I/O control block
`timescale 1ns/1ps
module remote_io_control_tb;
  logic clk_sys, reset_n, psel, penable, pwrite, fvalid, warn, st_pass, sup_ok, ack_req;
  logic pready, pslverr, spd_out, nf_out, prio_out, rly_spd, rly_ff, rly_warn;
  logic vent, motor, station, heat, seal, amatch, btick, er;
  logic [7:0] paddr, level, pins, err_c;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] setpt, rotor, spd_lvl;
  logic [9:0] faddr, tgt;
  int n_fail, checks_done, cyc;

  rio_remote_ctrl #(.SELFTEST_CYC(32'd40), .ACK_CYC(32'd20)) i_rio_remote_ctrl (
    .clk_sys_i(clk_sys), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .vent_enable_in_i(pins[0]), .motor_on_in_i(pins[1]), .station_on_in_i(pins[2]),
    .reduced_speed_in_i(pins[3]), .heater_in_i(pins[4]), .seal_gas_in_i(pins[5]),
    .fault_ack_in_i(pins[6]), .local_priority_in_i(pins[7]), .speed_setpoint_pos_i(setpt),
    .rotor_speed_pct_i(rotor), .error_cause_i(err_c), .warning_i(warn), .selftest_pass_i(st_pass),
    .supply_ok_i(sup_ok), .frame_addr_i(faddr), .frame_addr_valid_i(fvalid),
    .speed_reached_out_o(spd_out), .no_fault_out_o(nf_out), .priority_out_o(prio_out),
    .speed_level_out_o(spd_lvl), .relay_speed_o(rly_spd), .relay_fault_free_o(rly_ff),
    .relay_warning_o(rly_warn), .vent_permit_o(vent), .motor_run_o(motor), .station_run_o(station),
    .heater_on_o(heat), .seal_gas_open_o(seal), .target_speed_pml_o(tgt), .addr_match_o(amatch),
    .baud_tick_o(btick));

  rio_plc_model i_rio_plc_model (.clk_i(clk_sys), .level_i(level), .ack_req_i(ack_req), .pins_o(pins));

  // ****************************************
  // Clock, counters, hang guard
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Whole run needs about 30000 cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  // Checks sample at the falling edge, where registered outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  // Pin changes need the synchroniser plus the debounce time to show
  task automatic set_pins(input logic [7:0] v);
    @(posedge clk_sys);
    level <= v;
    settle(2520);
  endtask : set_pins

  // One APB transfer; request is held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb answer", n < 20, 1'b1);
  endtask : apb

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [7:0] adr [5] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h18};
    logic [31:0] exv [5] = '{32'h0, 32'h50, 32'h29B, 32'h1, 32'h0};
    for (int i = 0; i < 5; i++) begin
      apb(adr[i], 1'b0, 32'h0);
      chk("reg reset value", rd, exv[i]);
      chk("slave error", er, i == 4);
    end
    apb(8'h08, 1'b1, 32'h4B);
    rotor <= 7'd74;
    settle(3);
    chk("below switch point", {spd_out, rly_spd, spd_lvl}, {2'b00, 7'd74});
    rotor <= 7'd75;
    warn <= 1'b1;
    settle(3);
    chk("at switch point", {spd_out, rly_spd, rly_warn}, 3'b111);
    warn <= 1'b0;
    settle(3);
    chk("warning gone", rly_warn, 1'b0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_setpoint;
    logic [6:0] code [5] = '{7'd19, 7'd20, 7'd55, 7'd100, 7'd0};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_sys);
      setpt <= code[i];
      settle(4);
      chk("target speed", tgt, (code[i] < 20 || code[i] > 100) ? 10'd1000 : 10'(code[i]) * 10'd10);
    end
    $display("test setpoint done");
  endtask : t_setpoint

  task automatic t_pins;
    set_pins(8'h80);
    chk("priority out", prio_out, 1'b1);
    set_pins(8'hB1);
    chk("heater seal vent", {heat, seal, vent}, 3'b111);
    set_pins(8'hB9);
    chk("standby target", tgt, 10'd667);
    set_pins(8'hB1);
    chk("nominal target", tgt, 10'd1000);
    err_c <= 8'h01;
    @(posedge clk_sys);
    err_c <= 8'h00;
    settle(2);
    chk("error shown", {nf_out, rly_ff}, 2'b00);
    set_pins(8'hB7);
    chk("station on in test", {station, motor, nf_out}, 3'b101);
    settle(40);
    chk("motor after test", motor, 1'b1);
    apb(8'h04, 1'b0, 32'h0);
    chk("status word", rd, 32'h0000_23B7);
    set_pins(8'hB5);
    chk("motor off no vent", {motor, vent, station}, 3'b011);
    set_pins(8'hB7);
    chk("motor on no retest", motor, 1'b1);
    $display("test pins done");
  endtask : t_pins

  task automatic t_errors;
    err_c <= 8'h04;
    @(posedge clk_sys);
    err_c <= 8'h00;
    ack_req <= 1'b1;
    @(posedge clk_sys);
    ack_req <= 1'b0;
    settle(100);
    chk("pending before ack", {nf_out, rly_ff}, 2'b00);
    apb(8'h14, 1'b0, 32'h0);
    chk("pending flags", rd, 32'h0000_0004);
    settle(2600);
    chk("cleared by ack", {nf_out, rly_ff}, 2'b11);
    sup_ok <= 1'b0;
    settle(3);
    chk("no supply", nf_out, 1'b0);
    sup_ok <= 1'b1;
    $display("test errors done");
  endtask : t_errors

  task automatic t_release;
    set_pins(8'h00);
    chk("priority dropped", {prio_out, heat, station}, 3'b000);
    apb(8'h00, 1'b1, 32'h10);
    settle(3);
    chk("software heater", heat, 1'b1);
    apb(8'h00, 1'b1, 32'h0);
    set_pins(8'h10);
    chk("pin ignored", heat, 1'b0);
    $display("test release done");
  endtask : t_release

  task automatic t_serial;
    logic [9:0] ad [3] = '{10'h3C2, 10'h001, 10'h005};
    int n;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      faddr <= ad[i];
      fvalid <= 1'b1;
      @(posedge clk_sys);
      fvalid <= 1'b0;
      @(negedge clk_sys);
      chk("address match", amatch, i < 2);
    end
    n = 0;
    while (btick !== 1'b1 && n < 3000) begin
      settle(0);
      n++;
    end
    n = 0;
    do begin
      settle(1);
      n++;
    end while (btick !== 1'b1 && n < 3000);
    chk("baud period", n, 2604);
    $display("test serial done");
  endtask : t_serial

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    {reset_n, psel, penable, pwrite, fvalid, warn, ack_req} = '0;
    {st_pass, sup_ok} = 2'b11;
    {paddr, level, err_c, pwdata, setpt, rotor, faddr} = '0;
    {n_fail, checks_done, cyc} = '0;
    settle(19);
    chk("reset outputs", {tgt, nf_out, motor, station, pready}, {10'd1000, 4'h0});
    @(posedge clk_sys);
    reset_n <= 1'b1;
    t_regs();
    t_setpoint();
    t_pins();
    t_errors();
    t_release();
    t_serial();
    complete_run();
  end
endmodule : remote_io_control_tb
